// >>> rly_bus_if.sv
/*
  Relay board logic on the multi-board expansion ribbon bus: address match,
  nibble relay writes, coil sink and indicator drive, plus an APB slave for
  the factory code, board variant and status.
  Assumes bus strobes are active-high levels from pins, held long enough
  to pass the synchroniser, with data stable around each strobe.
*/
// Local design decisions: the APB register port and the register addresses.
// What this block does
// - Board matches only 000z 000y pppx; code plus jumpers give 64 addresses.
// - Jumper bit is 1 when open, 0 when fitted; z 5-6, y 3-4, x 1-2.
// - Selected write: D3..D1 pick the relay, D0 switches it on or off.
// - Any number of writes act while selected, without resending address.
// - Independent relays 0 to 7 (0 to 5 on the six-relay variant), each holding its last state.
// - Six-relay variant lights each indicator exactly while its coil drives.
// - Address nibbles of successive address cycles are compared; select on match.
// - Eight-relay board pulses one activity indicator on own address match.
// - Selection may change any time; no minimum spacing between accesses. Here only one strobe edge per pclk cycle is taken.
`timescale 1ns/1ps
`default_nettype none
module rly_bus_if
  import rly_pkg::*;
#(
  parameter int unsigned ACT_CYCLES = rly_pkg::RLY_ACT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rly_pkg::RLY_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_reset_cmd,
  input wire logic first_address_cycle,
  input wire logic second_address_cycle,
  input wire logic third_address_cycle,
  input wire logic data_write_cycle,
  input wire logic [rly_pkg::RLY_NIBBLE_W-1:0] bus_data,
  input wire logic [rly_pkg::RLY_JMP_W-1:0] address_jumper_block,
  output logic [rly_pkg::RLY_RELAYS-1:0] coil_sink,
  output logic [rly_pkg::RLY_RELAYS-1:0] coil_indicator,
  output logic activity_led
);
  import rly_pkg::*;

  localparam int unsigned STB_W = 5;
  localparam int unsigned STB_RST = 0;
  localparam int unsigned STB_A0 = 1;
  localparam int unsigned STB_A1 = 2;
  localparam int unsigned STB_A2 = 3;
  localparam int unsigned STB_WR = 4;
  localparam logic [RLY_ACT_W-1:0] ACT_LOAD = RLY_ACT_W'(ACT_CYCLES - 1);
  localparam logic [RLY_ACT_W-1:0] ACT_ZERO = '0;

  logic [STB_W-1:0] stb_level;
  logic [STB_W-1:0] stb_rise;
  logic [RLY_NIBBLE_W-1:0] data_s;
  logic [RLY_JMP_W-1:0] jmp_s;

  rly_pin_sync #(.W(STB_W)) u_stb_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({data_write_cycle, third_address_cycle, second_address_cycle,
          first_address_cycle, bus_reset_cmd}),
    .level(stb_level),
    .rise(stb_rise)
  );
  rly_pin_sync #(.W(RLY_NIBBLE_W + RLY_JMP_W)) u_dat_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({address_jumper_block, bus_data}),
    .level({jmp_s, data_s}),
    .rise()
  );

  // Expected address nibble for a given cycle
  function automatic logic [RLY_NIBBLE_W-1:0] adr_nibble(
    input logic [RLY_NIBBLE_W-2:0] hi,
    input logic bit0
  );
    adr_nibble = {hi, bit0};
  endfunction

  // Control and status state
  logic [RLY_CODE_W-1:0] factory_code;
  logic six_variant;
  logic first_ok;
  logic second_ok;
  logic selected;
  logic [RLY_RELAYS-1:0] relay_state;
  logic [RLY_ACT_W-1:0] act_cnt;
  logic [RLY_CODE_W-1:0] next_factory_code;
  logic next_six_variant;
  logic next_first_ok;
  logic next_second_ok;
  logic next_selected;
  logic [RLY_RELAYS-1:0] next_relay_state;
  logic [RLY_ACT_W-1:0] next_act_cnt;
  logic next_activity_led;
  logic [RLY_RELAYS-1:0] next_coil_indicator;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic apb_access;
  logic apb_commit;
  logic hit_ctrl;
  logic hit_stat;
  logic third_match;
  logic [RLY_IDX_W-1:0] wr_idx;
  logic [RLY_NIBBLE_W-1:0] want_a0;
  logic [RLY_NIBBLE_W-1:0] want_a1;
  logic [RLY_NIBBLE_W-1:0] want_a2;

  always_comb begin
    apb_access = psel && penable;
    apb_commit = apb_access && pready;
    hit_ctrl = (paddr == RLY_CTRL_OFS);
    hit_stat = (paddr == RLY_STAT_OFS);
    want_a0 = adr_nibble(RLY_ADR_FIXED, jmp_s[RLY_JMP_Z]);
    want_a1 = adr_nibble(RLY_ADR_FIXED, jmp_s[RLY_JMP_Y]);
    want_a2 = adr_nibble(factory_code, jmp_s[RLY_JMP_X]);
    third_match = first_ok && second_ok && (data_s == want_a2);
    wr_idx = data_s[RLY_WR_IDX_HI:RLY_WR_IDX_LO];

    next_factory_code = factory_code;
    next_six_variant = six_variant;
    next_first_ok = first_ok;
    next_second_ok = second_ok;
    next_selected = selected;
    next_relay_state = relay_state;
    next_act_cnt = (act_cnt != ACT_ZERO) ? act_cnt - 1'b1 : ACT_ZERO;

    if (apb_commit && pwrite && hit_ctrl) begin
      next_factory_code = pwdata[RLY_CTRL_CODE_HI:RLY_CTRL_CODE_LO];
      next_six_variant = pwdata[RLY_CTRL_SIX];
    end

    // One strobe edge acts per pclk, in priority reset, A0, A1, A2, write; a lower edge rising in the same cycle is lost
    if (stb_level[STB_RST]) begin
      next_first_ok = 1'b0;
      next_second_ok = 1'b0;
      next_selected = 1'b0;
      next_relay_state = '0;
    end else if (stb_rise[STB_A0]) begin
      next_first_ok = (data_s == want_a0);
      next_second_ok = 1'b0;
      next_selected = 1'b0;
    end else if (stb_rise[STB_A1]) begin
      next_second_ok = first_ok && (data_s == want_a1);
      next_selected = 1'b0;
    end else if (stb_rise[STB_A2]) begin
      // A lone third cycle reuses the prefix matched before
      next_selected = third_match;
      if (third_match && !six_variant) begin
        next_act_cnt = ACT_LOAD;
      end
    end else if (stb_rise[STB_WR] && selected) begin
      // Selection stays, so writes repeat freely
      if (!six_variant || (32'(wr_idx) < RLY_SIX_RELAYS)) begin
        next_relay_state[wr_idx] = data_s[RLY_WR_ON];
      end
    end
    if (next_six_variant) begin
      next_relay_state[RLY_RELAYS-1:RLY_SIX_RELAYS] = '0;
    end

    next_activity_led = (next_act_cnt != ACT_ZERO);
    next_coil_indicator = next_six_variant ? next_relay_state : '0;

    // One wait state, then the answer with registered read data
    next_pready = apb_access && !pready;
    next_pslverr = apb_access && !pready && !(hit_ctrl || hit_stat);
    next_prdata = RLY_ZERO_WORD;
    if (apb_access && !pready && !pwrite) begin
      if (hit_ctrl) begin
        next_prdata[RLY_CTRL_CODE_HI:RLY_CTRL_CODE_LO] = factory_code;
        next_prdata[RLY_CTRL_SIX] = six_variant;
      end else if (hit_stat) begin
        next_prdata[RLY_STAT_SEL] = selected;
        next_prdata[RLY_STAT_JMP_HI:RLY_STAT_JMP_LO] = jmp_s;
        next_prdata[RLY_STAT_RLY_HI:RLY_STAT_RLY_LO] = relay_state;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      factory_code <= RLY_CODE_RST;
      six_variant <= RLY_SIX_RST;
      first_ok <= 1'b0;
      second_ok <= 1'b0;
      selected <= 1'b0;
      relay_state <= '0;
      act_cnt <= ACT_ZERO;
      activity_led <= 1'b0;
      coil_sink <= '0;
      coil_indicator <= '0;
      prdata <= RLY_ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      factory_code <= next_factory_code;
      six_variant <= next_six_variant;
      first_ok <= next_first_ok;
      second_ok <= next_second_ok;
      selected <= next_selected;
      relay_state <= next_relay_state;
      act_cnt <= next_act_cnt;
      activity_led <= next_activity_led;
      coil_sink <= next_relay_state;
      coil_indicator <= next_coil_indicator;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule
`default_nettype wire

// >>> rly_bus_if_chk.sv
/*
  Port checker for rly_bus_if, bound to every instance.
  Assumes strobes held high at least four pclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rly_chk #(
  parameter int unsigned ACT_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic bus_reset_cmd,
  input wire logic third_address_cycle,
  input wire logic data_write_cycle,
  input wire logic [7:0] coil_sink,
  input wire logic [7:0] coil_indicator,
  input wire logic activity_led
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer after one wait state");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata outside answer");
  a_ind_follow: assert property (coil_indicator == coil_sink || coil_indicator == 8'h00)
    else $error("indicator differs from coil");
  a_reset_off: assert property (bus_reset_cmd [*5] |=> coil_sink == 8'h00)
    else $error("relays on during bus reset");
  a_coil_cause: assert property ($changed(coil_sink[5:0]) |->
    $past(data_write_cycle, 3) || $past(bus_reset_cmd, 3))
    else $error("coil changed without cause");
  a_act_cause: assert property ($rose(activity_led) |->
    $past(third_address_cycle, 3) || $past(third_address_cycle, 4))
    else $error("activity without address cycle");
  a_act_len: assert property ($rose(activity_led) |->
    activity_led [*7] ##[1:4] !activity_led)
    else $error("activity pulse length wrong");
  // Length of the current activity pulse in pclk cycles
  logic [31:0] act_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_run <= '0;
    end else if (activity_led) begin
      act_run <= act_run + 32'h0000_0001;
    end else begin
      act_run <= '0;
    end
  end
  a_act_count: assert property ($fell(activity_led) |-> act_run == ACT_CYCLES - 1)
    else $error("activity pulse count wrong");
endmodule
bind rly_bus_if rly_chk #(.ACT_CYCLES(ACT_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .bus_reset_cmd(bus_reset_cmd), .third_address_cycle(third_address_cycle),
  .data_write_cycle(data_write_cycle), .coil_sink(coil_sink),
  .coil_indicator(coil_indicator), .activity_led(activity_led));
`default_nettype wire

// >>> rly_host.sv
/*
  Expansion bus controller model: bus reset, address and write cycles.
  Assumes tasks are called just after a rising pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rly_host #(
  parameter int unsigned RST_WAIT = 16
) (
  input wire logic pclk,
  output logic bus_reset_cmd,
  output logic [3:0] strobe,
  output logic [3:0] bus_data
);
  initial begin
    bus_reset_cmd = 1'b0;
    strobe = 4'h0;
    bus_data = 4'h0;
  end
  // Strobe k: 0..2 address cycles, 3 data write; data released to inverse
  task automatic cyc(input int k, input logic [3:0] d);
    bus_data <= d;
    repeat (3) @(posedge pclk);
    strobe[k] <= 1'b1;
    repeat (4) @(posedge pclk);
    strobe[k] <= 1'b0;
    repeat (3) @(posedge pclk);
    bus_data <= ~d;
    @(posedge pclk);
  endtask
  task automatic bus_reset;
    bus_reset_cmd <= 1'b1;
    repeat (6) @(posedge pclk);
    bus_reset_cmd <= 1'b0;
    repeat (RST_WAIT) @(posedge pclk);
  endtask
  task automatic sel(input logic [2:0] ppp, input logic [2:0] zyx);
    cyc(0, {3'h0, zyx[2]});
    cyc(1, {3'h0, zyx[1]});
    cyc(2, {ppp, zyx[0]});
  endtask
endmodule
`default_nettype wire

// >>> rly_pin_sync.sv
/*
  Two-flop synchroniser for a group of expansion bus pins, with a rising
  edge pulse per bit taken from the synchronised level.
  Assumes asynchronous pin inputs and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rly_pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end
  assign level = sync;
  assign rise = sync & ~prev;
endmodule
`default_nettype wire

// >>> rly_pkg.sv
/*
  Shared constants of the relay board bus interface: expansion bus address
  layout, APB register map, field positions, reset values and timing.
  Assumes a 250 MHz pclk; nothing else outside.
*/
package rly_pkg;
  localparam int unsigned RLY_NIBBLE_W = 4;
  localparam int unsigned RLY_RELAYS = 8;
  localparam int unsigned RLY_SIX_RELAYS = 6;
  localparam int unsigned RLY_IDX_W = 3;
  localparam int unsigned RLY_CODE_W = 3;
  localparam int unsigned RLY_JMP_W = 3;
  // Jumper vector order: [2]=z (pair 5-6), [1]=y (pair 3-4), [0]=x (pair 1-2)
  localparam int unsigned RLY_JMP_Z = 2;
  localparam int unsigned RLY_JMP_Y = 1;
  localparam int unsigned RLY_JMP_X = 0;
  // Fixed upper bits of the first two address nibbles
  localparam logic [2:0] RLY_ADR_FIXED = 3'h0;
  // Write nibble layout
  localparam int unsigned RLY_WR_ON = 0;
  localparam int unsigned RLY_WR_IDX_LO = 1;
  localparam int unsigned RLY_WR_IDX_HI = 3;
  // APB map
  localparam int unsigned RLY_ADDR_W = 12;
  localparam logic [11:0] RLY_CTRL_OFS = 12'h000;
  localparam logic [11:0] RLY_STAT_OFS = 12'h004;
  localparam int unsigned RLY_CTRL_CODE_LO = 0;
  localparam int unsigned RLY_CTRL_CODE_HI = 2;
  localparam int unsigned RLY_CTRL_SIX = 3;
  localparam int unsigned RLY_STAT_SEL = 0;
  localparam int unsigned RLY_STAT_JMP_LO = 4;
  localparam int unsigned RLY_STAT_JMP_HI = 6;
  localparam int unsigned RLY_STAT_RLY_LO = 8;
  localparam int unsigned RLY_STAT_RLY_HI = 15;
  localparam logic [2:0] RLY_CODE_RST = 3'h0;
  localparam logic RLY_SIX_RST = 1'b0;
  localparam logic [31:0] RLY_ZERO_WORD = 32'h0000_0000;
  // Activity indicator pulse length
  localparam int unsigned RLY_CLK_KHZ = 250_000;
  localparam int unsigned RLY_ACT_MS = 20;
  localparam int unsigned RLY_ACT_CYCLES = RLY_ACT_MS * RLY_CLK_KHZ;
  localparam int unsigned RLY_ACT_W = 23;
endpackage

// >>> test_rly_bus_if.sv
/*
  Testbench for rly_bus_if: APB master tasks and bus cycle sequences.
  Assumes rly_host drives the expansion bus pins.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rly_bus_if;
  import rly_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, bus_reset_cmd, act, act_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] stb, bus_data;
  logic [2:0] jmp;
  logic [7:0] coil, ind, exp_c;
  int fails, tests_run;
  rly_bus_if #(.ACT_CYCLES(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_reset_cmd(bus_reset_cmd),
    .first_address_cycle(stb[0]), .second_address_cycle(stb[1]),
    .third_address_cycle(stb[2]), .data_write_cycle(stb[3]), .bus_data(bus_data),
    .address_jumper_block(jmp), .coil_sink(coil), .coil_indicator(ind), .activity_led(act));
  rly_host #(.RST_WAIT(16)) host (.pclk(pclk), .bus_reset_cmd(bus_reset_cmd), .strobe(stb),
    .bus_data(bus_data));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (!presetn) begin
      act_seen <= 1'b0;
    end else if (act === 1'b1) begin
      act_seen <= 1'b1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    jmp = 3'h5;
    exp_c = 8'h00;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, RLY_CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, RLY_CTRL_OFS, 32'h0000_0005);
    host.bus_reset();
    host.sel(3'h4, jmp);
    host.cyc(3, 4'h1);
    chk({31'h0, act_seen}, 32'h0000_0000);
    apb(1'b0, RLY_STAT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0050);
    host.sel(3'h5, jmp);
    chk({31'h0, act_seen}, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      host.cyc(3, {i[2:0], 1'b1});
      exp_c[i] = 1'b1;
      chk({24'h0, coil}, {24'h0, exp_c});
    end
    host.cyc(3, 4'h6);
    exp_c[3] = 1'b0;
    chk({24'h0, coil}, {24'h0, exp_c});
    chk({24'h0, ind}, 32'h0000_0000);
    jmp <= 3'h2;
    host.sel(3'h5, 3'h2);
    apb(1'b1, RLY_STAT_OFS, 32'h0000_0000);
    apb(1'b0, RLY_STAT_OFS, 32'h0000_0000);
    chk(rd, {16'h0, exp_c, 8'h21});
    apb(1'b1, RLY_CTRL_OFS, 32'h0000_000D);
    host.cyc(3, 4'hF);
    exp_c = exp_c & 8'h3F;
    chk({24'h0, coil}, {24'h0, exp_c});
    chk({24'h0, ind}, {24'h0, exp_c});
    host.bus_reset();
    host.cyc(3, 4'h1);
    chk({24'h0, coil}, 32'h0000_0000);
    host.cyc(2, 4'hA);
    apb(1'b0, RLY_STAT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0020);
    complete_run();
  end
endmodule
`default_nettype wire
